// ===== verilog/acs_sequencer.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "acs_regs.svh"
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter core
    output acs_core_req_s core_req,
    input wire logic [9:0] core_result,
    input wire logic rc_osc_in,
    // system
    input wire logic sleep_active,
    output logic wake_request,
    output logic clk_sel_invalid,
    // port pins
    input wire logic [4:0] port_pins_in,
    output logic [4:0] port_read_value
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [1:0] clk_sel_r;
    logic [2:0] chan_r;
    logic go_r;
    logic on_r;
    logic fmt_r;
    logic [3:0] pcfg_r;
    logic done_flag_r;
    logic irq_en_r;
    logic [7:0] res_hi_r;
    logic [7:0] res_lo_r;
    logic powered_down_r;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [9:0] aw_idx_r;
    logic [7:0] wdata_r;
    logic wlane_r;
    logic wr_fire;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] rd_byte;
    logic [9:0] ar_idx;

    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign ar_idx = s_axi_araddr[11:2];

    // address and data may come in either order; each is held until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_idx_r <= 10'h000;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr[11:2];
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // ready flops: accept only when the holding slot is empty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    // decode of the held write address
    always_comb begin
        case (aw_idx_r)
            `ACS_IDX_FLAGS, `ACS_IDX_RES_HI, `ACS_IDX_CTRL0,
            `ACS_IDX_ENABLES, `ACS_IDX_RES_LO, `ACS_IDX_CTRL1: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // write response, slverr on unmapped index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // write strobes per register, only byte lane 0 carries data
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_flags;
    logic wr_en;
    logic wr_hi;
    logic wr_lo;
    assign wr_ctrl0 = wr_fire && wlane_r && (aw_idx_r == `ACS_IDX_CTRL0);
    assign wr_ctrl1 = wr_fire && wlane_r && (aw_idx_r == `ACS_IDX_CTRL1);
    assign wr_flags = wr_fire && wlane_r && (aw_idx_r == `ACS_IDX_FLAGS);
    assign wr_en = wr_fire && wlane_r && (aw_idx_r == `ACS_IDX_ENABLES);
    assign wr_hi = wr_fire && wlane_r && (aw_idx_r == `ACS_IDX_RES_HI);
    assign wr_lo = wr_fire && wlane_r && (aw_idx_r == `ACS_IDX_RES_LO);

    // read mux, unimplemented bits read zero
    always_comb begin
        rd_ok = 1'b1;
        case (ar_idx)
            `ACS_IDX_FLAGS: rd_byte = {1'b0, done_flag_r, 6'h00};
            `ACS_IDX_RES_HI: rd_byte = res_hi_r;
            `ACS_IDX_CTRL0: rd_byte = {clk_sel_r, chan_r, go_r, 1'b0, on_r};
            `ACS_IDX_ENABLES: rd_byte = {1'b0, irq_en_r, 6'h00};
            `ACS_IDX_RES_LO: rd_byte = res_lo_r;
            `ACS_IDX_CTRL1: rd_byte = {fmt_r, 3'h0, pcfg_r};
            default: begin
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    // read data captured at address acceptance, answered next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // bit period generation
    // ----------------------------------------------------------------
    logic rc_sync1_r;
    logic rc_sync2_r;
    logic rc_prev_r;
    logic [5:0] tad_cnt_r;
    logic [5:0] tad_len;
    logic tad_tick;
    logic start_conv;
    acs_state_e state_r;
    acs_state_e state_nxt;

    // rc synchroniser: first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_sync1_r <= 1'b0;
            rc_sync2_r <= 1'b0;
            rc_prev_r <= 1'b0;
        end else begin
            rc_sync1_r <= rc_osc_in;
            rc_sync2_r <= rc_sync1_r;
            rc_prev_r <= rc_sync2_r;
        end
    end

    always_comb begin
        case (clk_sel_r)
            `ACS_CLK_DIV2: tad_len = `ACS_DIV2_CYC;
            `ACS_CLK_DIV8: tad_len = `ACS_DIV8_CYC;
            default: tad_len = `ACS_DIV32_CYC;
        endcase
    end

    // one tick per bit period; rc rising edge when rc selected
    assign tad_tick = (clk_sel_r == `ACS_CLK_RC) ? (rc_sync2_r && !rc_prev_r)
                                                  : (tad_cnt_r == tad_len - 6'h01);

    // divider restarts at go so first tick lands one full bit period later
    always_ff @(posedge aclk) begin
        if (!aresetn || start_conv || tad_tick) begin
            tad_cnt_r <= 6'h00;
        end else begin
            tad_cnt_r <= tad_cnt_r + 6'h01;
        end
    end

    // flag options beyond their frequency limit or below least period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sel_invalid <= 1'b0;
        end else begin
            case (clk_sel_r)
                `ACS_CLK_DIV2: clk_sel_invalid <= (`ACS_FOSC_HZ > `ACS_FMAX_DIV2_HZ)
                    || (`ACS_DIV2_CYC < 6'(`ACS_TAD_MIN_CYC));
                `ACS_CLK_DIV8: clk_sel_invalid <= (`ACS_FOSC_HZ > `ACS_FMAX_DIV8_HZ)
                    || (`ACS_DIV8_CYC < 6'(`ACS_TAD_MIN_CYC));
                `ACS_CLK_DIV32: clk_sel_invalid <= (`ACS_FOSC_HZ > `ACS_FMAX_DIV32_HZ)
                    || (`ACS_DIV32_CYC < 6'(`ACS_TAD_MIN_CYC));
                default: clk_sel_invalid <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_r;
    logic [1:0] hold_cnt_r;
    logic [2:0] tcy_cnt_r;
    logic tcy_done;
    logic running;
    logic complete;
    logic sw_abort;
    logic sleep_abort;

    assign running = (state_r == ST_DELAY) || (state_r == ST_CONV);
    assign tcy_done = (tcy_cnt_r == 3'(`ACS_TCY_CYC));
    assign start_conv = (state_r == ST_ACQ) && go_r && on_r && !powered_down_r;
    // sleep without rc clock stops everything
    assign sleep_abort = sleep_active && (clk_sel_r != `ACS_CLK_RC) && on_r;
    assign sw_abort = wr_ctrl0 && !wdata_r[`ACS_C0_GO] && running;
    // completion on the twelfth bit period
    assign complete = (state_r == ST_CONV) && go_r && tad_tick
                      && (bit_cnt_r == `ACS_CONV_TADS - 4'h1);

    // next state
    always_comb begin
        state_nxt = state_r;
        if (!on_r || powered_down_r || sleep_abort) begin
            // converter off shuts down the sequence
            state_nxt = ST_OFF;
        end else begin
            case (state_r)
                ST_OFF: state_nxt = ST_ACQ;
                ST_ACQ: if (start_conv) state_nxt = ST_DELAY;
                // wait one instruction cycle before first bit
                ST_DELAY: begin
                    if (sw_abort || !go_r) state_nxt = ST_HOLD;
                    else if (tcy_done && tad_tick) state_nxt = ST_CONV;
                end
                ST_CONV: begin
                    if (sw_abort || !go_r || complete) state_nxt = ST_HOLD;
                end
                // two bit periods disconnected, then acquire again
                ST_HOLD: begin
                    if (tad_tick && hold_cnt_r == `ACS_HOLD_TADS - 2'h1) state_nxt = ST_ACQ;
                end
                default: state_nxt = ST_OFF;
            endcase
        end
    end

    // state register; reset lands in off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // instruction-cycle, bit and hold counters
    always_ff @(posedge aclk) begin
        if (!aresetn || start_conv) begin
            tcy_cnt_r <= 3'h0;
            bit_cnt_r <= 4'h0;
            hold_cnt_r <= 2'h0;
        end else begin
            if (!tcy_done) tcy_cnt_r <= tcy_cnt_r + 3'h1;
            if (state_r == ST_CONV && tad_tick) bit_cnt_r <= bit_cnt_r + 4'h1;
            if (state_r != ST_HOLD) hold_cnt_r <= 2'h0;
            else if (tad_tick) hold_cnt_r <= hold_cnt_r + 2'h1;
        end
    end

    // core commands registered from the next state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_req <= '0;
        end else begin
            core_req.powered <= (state_nxt != ST_OFF);
            core_req.sample_connect <= (state_nxt == ST_ACQ) || (state_nxt == ST_DELAY);
            core_req.convert <= (state_nxt == ST_CONV);
            // channel passed through regardless of pin direction
            core_req.channel <= chan_r;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // reset images held as typed constants so their fields can be selected
    localparam logic [7:0] CTRL0_RST = `ACS_CTRL0_RST;
    localparam logic [7:0] CTRL1_RST = `ACS_CTRL1_RST;

    // control bits reset to zero, all pins analog
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {clk_sel_r, chan_r} <= CTRL0_RST[`ACS_C0_CLKSEL_HI:`ACS_C0_CHAN_LO];
            on_r <= CTRL0_RST[`ACS_C0_ON];
            {fmt_r, pcfg_r} <= {CTRL1_RST[`ACS_C1_FMT], CTRL1_RST[`ACS_C1_PCFG_HI:`ACS_C1_PCFG_LO]};
            irq_en_r <= 1'b0;
        end else begin
            if (wr_ctrl0) begin
                clk_sel_r <= wdata_r[`ACS_C0_CLKSEL_HI:`ACS_C0_CLKSEL_LO];
                chan_r <= wdata_r[`ACS_C0_CHAN_HI:`ACS_C0_CHAN_LO];
                on_r <= wdata_r[`ACS_C0_ON];
            end
            if (wr_ctrl1) begin
                fmt_r <= wdata_r[`ACS_C1_FMT];
                pcfg_r <= wdata_r[`ACS_C1_PCFG_HI:`ACS_C1_PCFG_LO];
            end
            if (wr_en) irq_en_r <= wdata_r[`ACS_EN_DONE];
        end
    end

    // go flag: hardware clears on completion, abort or shutdown
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_r <= 1'b0;
        end else if (complete || sleep_abort || !on_r || powered_down_r) begin
            // go cleared in the completion cycle
            go_r <= 1'b0;
        end else if (wr_ctrl0) begin
            // go only takes when converter was already on
            go_r <= wdata_r[`ACS_C0_GO];
        end
    end

    // done flag: a completion wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag_r <= 1'b0;
        end else if (complete) begin
            // flag set with the result load
            done_flag_r <= 1'b1;
        end else if (wr_flags) begin
            done_flag_r <= wdata_r[`ACS_FLAG_DONE];
        end
    end

    // power down in sleep, on bit left set; awake clears it
    always_ff @(posedge aclk) begin
        if (!aresetn || !sleep_active) begin
            powered_down_r <= 1'b0;
        end else if (sleep_abort || (complete && !irq_en_r)) begin
            powered_down_r <= 1'b1;
        end
    end

    // wake pulse on completion in sleep with irq enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= complete && sleep_active && irq_en_r;
        end
    end

    // ----------------------------------------------------------------
    // result pair: no reset so contents survive any reset
    // ----------------------------------------------------------------
    // plain storage when no conversion overwrites it
    always_ff @(posedge aclk) begin
        if (complete) begin
            if (fmt_r) begin
                res_hi_r <= {6'h00, core_result[9:8]};
                res_lo_r <= core_result[7:0];
            end else begin
                res_hi_r <= core_result[9:2];
                res_lo_r <= {core_result[1:0], 6'h00};
            end
        end else begin
            if (wr_hi) res_hi_r <= wdata_r;
            if (wr_lo) res_lo_r <= wdata_r;
        end
    end

    // ----------------------------------------------------------------
    // port read masking
    // ----------------------------------------------------------------
    logic [4:0] digital_mask;

    // pin config decode, 1 marks a digital pin (an4..an0)
    always_comb begin
        case (pcfg_r)
            4'h4, 4'h5: digital_mask = 5'h14;
            4'h6, 4'h7: digital_mask = 5'h1f;
            4'hd: digital_mask = 5'h10;
            4'he: digital_mask = 5'h1e;
            4'hf: digital_mask = 5'h12;
            default: digital_mask = 5'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_read_value <= 5'h00;
        end else begin
            port_read_value <= port_pins_in & digital_mask;
        end
    end

endmodule // acs_sequencer

`default_nettype wire

// ===== verilog/acs_regs.svh
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACS_IDX_FLAGS 10'h00c
`define ACS_IDX_RES_HI 10'h01e
`define ACS_IDX_CTRL0 10'h01f
`define ACS_IDX_ENABLES 10'h08c
`define ACS_IDX_RES_LO 10'h09e
`define ACS_IDX_CTRL1 10'h09f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACS_C0_CLKSEL_HI 7
`define ACS_C0_CLKSEL_LO 6
`define ACS_C0_CHAN_HI 5
`define ACS_C0_CHAN_LO 3
`define ACS_C0_GO 2
`define ACS_C0_ON 0
`define ACS_C1_FMT 7
`define ACS_C1_PCFG_HI 3
`define ACS_C1_PCFG_LO 0
`define ACS_FLAG_DONE 6
`define ACS_EN_DONE 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACS_CTRL0_RST 8'h00
`define ACS_CTRL1_RST 8'h00

// ----------------------------------------------------------------
// clock select codes and timing
// ----------------------------------------------------------------
`define ACS_CLK_DIV2 2'h0
`define ACS_CLK_DIV8 2'h1
`define ACS_CLK_DIV32 2'h2
`define ACS_CLK_RC 2'h3
`define ACS_DIV2_CYC 6'h02
`define ACS_DIV8_CYC 6'h08
`define ACS_DIV32_CYC 6'h20
`define ACS_CONV_TADS 4'hc
`define ACS_HOLD_TADS 2'h2
`define ACS_CLK_PERIOD_NS 100
`define ACS_TCY_NS 400
`define ACS_TCY_CYC (`ACS_TCY_NS / `ACS_CLK_PERIOD_NS)
`define ACS_TAD_MIN_NS 1600
`define ACS_TAD_MIN_CYC ((`ACS_TAD_MIN_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_FOSC_HZ 10000000
`define ACS_FMAX_DIV2_HZ 1250000
`define ACS_FMAX_DIV8_HZ 5000000
`define ACS_FMAX_DIV32_HZ 20000000

`endif

// ===== verilog/acs_pkg.sv
`default_nettype none

package acs_pkg;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_ACQ = 5'h02,
        ST_DELAY = 5'h04,
        ST_CONV = 5'h08,
        ST_HOLD = 5'h10
    } acs_state_e;

    // commands to the sampling converter core
    typedef struct packed {
        logic powered;
        logic sample_connect;
        logic convert;
        logic [2:0] channel;
    } acs_core_req_s;

endpackage

`default_nettype wire

// ===== bench/acs_sequencer_properties.sv
`default_nettype none
module acs_seq_props
    import acs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched signals
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire acs_core_req_s core_req,
    input wire logic wake_request,
    input wire logic sleep_active,
    input wire logic clk_sel_invalid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> core_req == '0 && !wake_request)
        else $error("sequencer active after reset");
    AST_HOLD_AFTER: assert property ($fell(core_req.convert) |-> (!core_req.sample_connect)[*2])
        else $error("sampler reconnected too soon");
    AST_CONV_MIN: assert property ($rose(core_req.convert) |-> core_req.convert[*8])
        else $error("conversion too short");
    AST_CONV_POWERED: assert property (core_req.convert |-> core_req.powered)
        else $error("converting while unpowered");
    AST_ACQ_POWERED: assert property (core_req.sample_connect |-> core_req.powered)
        else $error("sampling while unpowered");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_WAKE_PULSE: assert property (wake_request |-> $past(sleep_active) ##1 !wake_request)
        else $error("bad wake pulse");
    AST_SLEEP_OFF: assert property (sleep_active && clk_sel_invalid |-> ##[0:4] !core_req.powered)
        else $error("converter kept on in sleep");
    // main scenarios seen
    cover property ($fell(core_req.convert));
    cover property (wake_request);
    cover property (sleep_active && clk_sel_invalid);
endmodule // acs_seq_props

bind acs_sequencer acs_seq_props acs_seq_props_i (.aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid,
    .core_req, .wake_request, .sleep_active, .clk_sel_invalid);
`default_nettype wire

// ===== bench/acs_core_model.sv
`default_nettype none
module acs_core_model
    import acs_pkg::*;
#(
    parameter logic [9:0] RESULT = 10'h2d9
)
(
    // clock and commands
    input wire logic aclk,
    input wire acs_core_req_s core_req,
    // converter answers
    output logic [9:0] core_result,
    output logic rc_osc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // free rc oscillator, phase unrelated to aclk
    initial begin
        rc_osc_in = 1'h0;
        forever #170 rc_osc_in = ~rc_osc_in;
    end
    // converts any channel
    // value churns unless converting, so a stale sample shows
    always @(posedge aclk) core_result <= core_req.convert ? RESULT : ~core_result;
endmodule // acs_core_model
`default_nettype wire

// ===== bench/tb_acs_sequencer.sv
`include "acs_regs.svh"
`default_nettype none
module tb_acs_sequencer
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, sleep_active = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    acs_core_req_s core_req;
    logic [9:0] core_result;
    logic rc_osc_in, wake_request, clk_sel_invalid;
    logic [4:0] port_pins_in = 5'h1f, port_read_value;
    int fail_count = 0, checks = 0, n;
    // 10 mhz clock
    always #50 aclk = ~aclk;
    acs_sequencer acs_sequencer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .core_req, .core_result, .rc_osc_in, .sleep_active, .wake_request,
        .clk_sel_invalid, .port_pins_in, .port_read_value);
    acs_core_model acs_core_model_i (.aclk, .core_req, .core_result, .rc_osc_in);
    // compare and log
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // write: address and data offered together, readies read between edges
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    // read and compare data and response
    task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!tr);
        s_axi_rready <= 1'h0;
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // bounded wait for converting (1) or acquiring (0)
    task automatic wait_on(input bit cv);
        for (n = 0; n < 2000; n++) begin
            @(negedge aclk);
            if (cv ? core_req.convert : core_req.sample_connect) break;
        end
        chk("phase", 32'h1, {31'h0, cv ? core_req.convert : core_req.sample_connect});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // cut a hang short
    initial begin
        #3000000;
        fail_count++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(`ACS_IDX_CTRL0, 32'h0, 2'h0);
        rd(`ACS_IDX_CTRL1, 32'h0, 2'h0);
        chk("pins", 32'h0, {27'h0, port_read_value});
        rd(10'h000, 32'h0, 2'h2);
        wr(10'h001, 8'h5a, 2'h2);
        wr(`ACS_IDX_RES_HI, 8'ha5, 2'h0);
        rd(`ACS_IDX_RES_HI, 32'ha5, 2'h0);
        wr(`ACS_IDX_CTRL0, 8'h81, 2'h0);
        @(negedge aclk);
        chk("badclk", 32'h0, {31'h0, clk_sel_invalid});
        wait_on(0);
        for (int f = 0; f < 2; f++) begin
            wr(`ACS_IDX_CTRL1, f ? 8'h84 : 8'h04, 2'h0);
            @(negedge aclk);
            chk("pins", 32'h14, {27'h0, port_read_value});
            wr(`ACS_IDX_CTRL0, 8'h85, 2'h0);
            rd(`ACS_IDX_CTRL0, 32'h85, 2'h0);
            wait_on(1);
            wait_on(0);
            rd(`ACS_IDX_CTRL0, 32'h81, 2'h0);
            rd(`ACS_IDX_RES_HI, f ? 32'h02 : 32'hb6, 2'h0);
            rd(`ACS_IDX_RES_LO, f ? 32'hd9 : 32'h40, 2'h0);
            rd(`ACS_IDX_FLAGS, 32'h40, 2'h0);
            wr(`ACS_IDX_FLAGS, 8'h00, 2'h0);
        end
        wr(`ACS_IDX_RES_LO, 8'h11, 2'h0);
        wr(`ACS_IDX_CTRL0, 8'h85, 2'h0);
        wait_on(1);
        repeat (20) @(posedge aclk);
        wr(`ACS_IDX_CTRL0, 8'h81, 2'h0);
        wait_on(0);
        chk("acq", 32'h1, {31'h0, core_req.sample_connect});
        rd(`ACS_IDX_RES_LO, 32'h11, 2'h0);
        rd(`ACS_IDX_FLAGS, 32'h0, 2'h0);
        wr(`ACS_IDX_ENABLES, 8'h40, 2'h0);
        wr(`ACS_IDX_CTRL0, 8'hc1, 2'h0);
        wait_on(0);
        wr(`ACS_IDX_CTRL0, 8'hc5, 2'h0);
        sleep_active <= 1'h1;
        for (n = 0; n < 3000 && !wake_request; n++) @(negedge aclk);
        chk("wake", 32'h1, {31'h0, wake_request});
        @(posedge aclk);
        sleep_active <= 1'h0;
        rd(`ACS_IDX_CTRL0, 32'hc1, 2'h0);
        rd(`ACS_IDX_RES_LO, 32'hd9, 2'h0);
        wr(`ACS_IDX_CTRL0, 8'h41, 2'h0);
        @(negedge aclk);
        chk("badclk", 32'h1, {31'h0, clk_sel_invalid});
        wait_on(0);
        wr(`ACS_IDX_CTRL0, 8'h45, 2'h0);
        wait_on(1);
        repeat (10) @(posedge aclk);
        sleep_active <= 1'h1;
        repeat (6) @(posedge aclk);
        chk("pwr", 32'h0, {31'h0, core_req.powered});
        sleep_active <= 1'h0;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`ACS_IDX_CTRL0, 32'h0, 2'h0);
        rd(`ACS_IDX_RES_HI, 32'h02, 2'h0);
        complete_run();
    end
endmodule // tb_acs_sequencer
`default_nettype wire
